// File: bench/pcg_periph_model.sv
// model of the gated peripherals: counts clock pulses, flags short ones
`timescale 1ns/10ps
`default_nettype none
module pcg_periph_model
(
   input wire logic [14:0] clks, // gated clocks, one per peripheral
   output var int edges [15], // rising edges seen per lane
   output var logic [14:0] runt // a too short high phase was seen
);
   genvar g;
   // a runt pulse would upset peripheral flops, so every high phase is timed
   for (g = 0; g < 15; g++)
   begin : lane
      realtime t_up = 0.0;
      initial edges[g] = 0;
      initial runt[g] = 1'b0;
      always @(posedge clks[g])
      begin
         t_up = $realtime;
         edges[g] = edges[g] + 1;
      end
      always @(negedge clks[g])
         if ($realtime - t_up < 9.5) runt[g] = 1'b1;
   end
endmodule
`default_nettype wire

// File: bench/pcg_sva.sv
// assertion checker for the clock gating register slave
`timescale 1ns/10ps
`default_nettype none
`include "pcg_consts.vh"
module pcg_sva
(
   input wire logic clock, // system clock
   input wire logic arst_n, // async reset, low
   input wire logic s_axi_awready, // aw ready
   input wire logic s_axi_wready, // w ready
   input wire logic s_axi_bvalid, // b valid
   input wire logic s_axi_bready, // b ready
   input wire logic [1:0] s_axi_bresp, // b resp
   input wire logic [11:0] s_axi_araddr, // ar addr
   input wire logic s_axi_arvalid, // ar valid
   input wire logic s_axi_arready, // ar ready
   input wire logic [31:0] s_axi_rdata, // r data
   input wire logic [1:0] s_axi_rresp, // r resp
   input wire logic s_axi_rvalid, // r valid
   input wire logic s_axi_rready, // r ready
   input wire logic unlocked // protection lifted
);
   logic [11:0] last_ra;
   // the answer carries no address, so remember the one taken
   always @(posedge clock or negedge arst_n)
      if (!arst_n) last_ra <= 12'h000;
      else if (s_axi_arvalid && s_axi_arready) last_ra <= s_axi_araddr;
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   sequence rd_take; s_axi_arvalid && s_axi_arready; endsequence
   sequence rd_bad; rd_take ##0 !(s_axi_araddr inside {`PCG_OFF_FAST, `PCG_OFF_PERIPH, `PCG_OFF_UNLOCK}); endsequence
   a_read_answer: assert property (rd_take |=> s_axi_rvalid) else $error("read not answered");
   a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("taken while busy");
   a_fast_reserved: assert property (s_axi_rvalid && last_ra == `PCG_OFF_FAST |-> (s_axi_rdata & ~`PCG_FAST_MASK) == 0)
      else $error("fast reserved bits set");
   a_periph_reserved: assert property (s_axi_rvalid && last_ra == `PCG_OFF_PERIPH |-> (s_axi_rdata & ~`PCG_PERIPH_MASK) == 0)
      else $error("periph reserved bits set");
   a_unlock_view: assert property (s_axi_rvalid && last_ra == `PCG_OFF_UNLOCK |-> s_axi_rdata[0] == unlocked)
      else $error("unlock status misread");
   a_unlock_write: assert property ($rose(unlocked) |-> $rose(s_axi_bvalid)) else $error("unlock without write");
   a_unmapped_read: assert property (rd_bad |=> s_axi_rresp == `PCG_RESP_SLVERR && s_axi_rdata == 0)
      else $error("unmapped read answered");
endmodule
bind pcg_top pcg_sva CHK (.*);
`default_nettype wire

// File: bench/testbench.sv
// self-checking bench for the peripheral clock gating block
`timescale 1ns/10ps
`default_nettype none
`include "pcg_consts.vh"
module testbench;
   logic clock = 1'b0, arst_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, unlocked;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [14:0] clks, runt;
   int edges [15];
   int n_errors = 0, total_checks = 0;
   int pbit [14] = '{0, 2, 3, 4, 5, 6, 8, 9, 12, 16, 17, 18, 24, 28};
   pcg_top DUT (.*, .flash_prog_clk(clks[14]), .adc_clk(clks[13]), .can_ctrl_clk(clks[12]),
      .serial_port2_clk(clks[11]), .serial_port1_clk(clks[10]), .serial_port0_clk(clks[9]), .spi_ctrl_clk(clks[8]),
      .i2c_ctrl1_clk(clks[7]), .i2c_ctrl0_clk(clks[6]), .freq_divider_clk(clks[5]), .timer3_clk(clks[4]),
      .timer2_clk(clks[3]), .timer1_clk(clks[2]), .timer0_clk(clks[1]), .watchdog_clk(clks[0]));
   pcg_periph_model PEER (.clks(clks), .edges(edges), .runt(runt));
   initial
   begin
      forever #10 clock = ~clock;
   end
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // bus write; valid dropped per channel once taken, bready held until answer
   // the waits have no limit of their own: a hung bus is ended by the watchdog
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      check("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      check("rdata", exp, s_axi_rdata);
      check("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
      s_axi_rready <= 1'b0;
   endtask
   // counted on falling edges so pulse counts never race the rising edge
   task automatic lanes(input logic [31:0] fv, input logic [31:0] pv);
      int snap [15];
      @(negedge clock);
      snap = edges;
      repeat (8) @(negedge clock);
      for (int i = 0; i < 15; i++) check("lane", (i == 14 ? fv[2] : pv[pbit[i]]) ? 32'h8 : 32'h0, edges[i] - snap[i]);
      check("runt", 32'h0, {17'h0, runt});
   endtask
   task automatic t_walk();
      rd(`PCG_OFF_FAST, 32'h4, 2'h0);
      rd(`PCG_OFF_PERIPH, 32'h0, 2'h0);
      lanes(32'h4, 32'h0);
      for (int i = 1; i < 14; i++)
      begin
         wr(`PCG_OFF_PERIPH, 32'h1 << pbit[i], 2'h0);
         lanes(32'h4, 32'h1 << pbit[i]);
      end
   endtask
   // reserved bits, locked watchdog bit, fast register and unmapped place
   task automatic t_protect();
      wr(`PCG_OFF_PERIPH, 32'hFFFFFFFF, 2'h0);
      rd(`PCG_OFF_PERIPH, 32'h1107137C, 2'h0);
      s_axi_wstrb <= 4'h2;
      wr(`PCG_OFF_PERIPH, 32'h0, 2'h0);
      s_axi_wstrb <= 4'hF;
      rd(`PCG_OFF_PERIPH, 32'h1107007C, 2'h0);
      wr(`PCG_OFF_FAST, 32'h0, 2'h0);
      lanes(32'h0, 32'h1107007C);
      wr(`PCG_OFF_FAST, 32'hFFFFFFFF, 2'h0);
      rd(`PCG_OFF_FAST, 32'h4, 2'h0);
      wr(12'h00C, 32'hFFFFFFFF, `PCG_RESP_SLVERR);
      rd(12'h00C, 32'h0, `PCG_RESP_SLVERR);
   endtask
   // key opens the watchdog bit; a wrong key closes it again
   task automatic t_unlock();
      wr(`PCG_OFF_UNLOCK, 32'h59, 2'h0);
      wr(`PCG_OFF_UNLOCK, 32'h16, 2'h0);
      wr(`PCG_OFF_UNLOCK, 32'h88, 2'h0);
      rd(`PCG_OFF_UNLOCK, 32'h1, 2'h0);
      check("unlocked", 32'h1, {31'h0, unlocked});
      wr(`PCG_OFF_PERIPH, 32'h1, 2'h0);
      lanes(32'h4, 32'h1);
      wr(`PCG_OFF_UNLOCK, 32'h0, 2'h0);
      check("unlocked", 32'h0, {31'h0, unlocked});
      wr(`PCG_OFF_PERIPH, 32'h0, 2'h0);
      rd(`PCG_OFF_PERIPH, 32'h1, 2'h0);
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // the sequence needs well under 2000 cycles
   initial
   begin
      #100000;
      n_errors++;
      finish_test();
   end
   initial
   begin
      repeat (20) @(posedge clock);
      arst_n <= 1'b1;
      t_walk();
      t_protect();
      t_unlock();
      finish_test();
   end
endmodule
`default_nettype wire

// File: core/pcg_gate.v
// glitch-free clock gate cell: enable retimed while the clock is low
`timescale 1ns/10ps
`default_nettype none
module pcg_gate
(
   input wire clk_in, // clock to be gated
   input wire enable, // gate enable, synchronous to clk_in
   output wire clk_out // gated clock
);
   reg en_hold;
   // enable retimed on the falling edge, so it can only change while the clock is low
   always @(negedge clk_in)
   begin
      en_hold <= enable;
   end
   // a flop instead of a latch: same glitch-free window, no level-sensitive storage to time
   assign clk_out = clk_in & en_hold;
endmodule
`default_nettype wire

// File: core/pcg_top.v
// peripheral clock gating controller with AXI4-Lite register slave
`timescale 1ns/10ps
`default_nettype none
`include "pcg_consts.vh"
module pcg_top
(
   input wire clock, // system bus clock, 50 MHz
   input wire arst_n, // asynchronous reset, active low
   input wire [11:0] s_axi_awaddr, // write address
   input wire s_axi_awvalid, // write address valid
   output reg s_axi_awready, // write address ready
   input wire [31:0] s_axi_wdata, // write data
   input wire [3:0] s_axi_wstrb, // write byte strobes
   input wire s_axi_wvalid, // write data valid
   output reg s_axi_wready, // write data ready
   output reg [1:0] s_axi_bresp, // write response
   output reg s_axi_bvalid, // write response valid
   input wire s_axi_bready, // write response ready
   input wire [11:0] s_axi_araddr, // read address
   input wire s_axi_arvalid, // read address valid
   output reg s_axi_arready, // read address ready
   output reg [31:0] s_axi_rdata, // read data
   output reg [1:0] s_axi_rresp, // read response
   output reg s_axi_rvalid, // read valid
   input wire s_axi_rready, // read ready
   output reg unlocked, // protection lifted status
   output wire flash_prog_clk, // gated flash programming clock
   output wire adc_clk, // gated converter clock
   output wire can_ctrl_clk, // gated CAN clock
   output wire serial_port2_clk, // gated serial port 2 clock
   output wire serial_port1_clk, // gated serial port 1 clock
   output wire serial_port0_clk, // gated serial port 0 clock
   output wire spi_ctrl_clk, // gated SPI clock
   output wire i2c_ctrl1_clk, // gated I2C 1 clock
   output wire i2c_ctrl0_clk, // gated I2C 0 clock
   output wire freq_divider_clk, // gated divider output clock
   output wire timer3_clk, // gated timer 3 clock
   output wire timer2_clk, // gated timer 2 clock
   output wire timer1_clk, // gated timer 1 clock
   output wire timer0_clk, // gated timer 0 clock
   output wire watchdog_clk // gated watchdog clock
);

   // ************************************************************
   // registers and write path state
   // ************************************************************
   reg [31:0] fast_bus_clock_gate;
   reg [31:0] peripheral_bus_clock_gate;
   reg [2:0] key_stage; // one-hot place in the unlock key sequence
   reg aw_held;
   reg w_held;
   reg [11:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   wire do_write;
   wire [31:0] strb_mask;
   wire [31:0] next_fast;
   wire [31:0] next_periph;
   wire [31:0] periph_mask_eff;
   wire aw_is_fast;
   wire aw_is_periph;
   wire aw_is_unlock;
   wire aw_mapped;
   wire ar_is_fast;
   wire ar_is_periph;
   wire ar_is_unlock;

   // unlock sequencer states, one-hot so each state is a single flop
   localparam KEY_IDLE = 3'h1;
   localparam KEY_GOT1 = 3'h2;
   localparam KEY_GOT2 = 3'h4;

   // word decode; byte offset bits are ignored because every register is one aligned word
   function reg_hit;
      input [11:0] addr;
      input [11:0] offset;
      begin
         reg_hit = (addr[11:2] == offset[11:2]);
      end
   endfunction

   // merge byte lanes of new data over the old value
   function [31:0] merge_lanes;
      input [31:0] old_val;
      input [31:0] new_val;
      input [31:0] lane_mask;
      input [31:0] field_mask;
      begin
         merge_lanes = ((old_val & ~lane_mask) | (new_val & lane_mask)) & field_mask;
      end
   endfunction

   assign strb_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
   assign do_write = aw_held && w_held && !s_axi_bvalid;
   // watchdog bit only writable while unlocked
   assign periph_mask_eff = unlocked ? `PCG_PERIPH_MASK : (`PCG_PERIPH_MASK & 32'hFFFFFFFE);
   assign next_fast = merge_lanes(fast_bus_clock_gate, w_data, strb_mask, `PCG_FAST_MASK);
   assign next_periph = merge_lanes(peripheral_bus_clock_gate, w_data, strb_mask, periph_mask_eff)
      | (peripheral_bus_clock_gate & ~periph_mask_eff & `PCG_PERIPH_MASK);

   // decode of the held write address and the offered read address
   assign aw_is_fast = reg_hit(aw_addr, `PCG_OFF_FAST);
   assign aw_is_periph = reg_hit(aw_addr, `PCG_OFF_PERIPH);
   assign aw_is_unlock = reg_hit(aw_addr, `PCG_OFF_UNLOCK);
   assign aw_mapped = aw_is_fast | aw_is_periph | aw_is_unlock;
   assign ar_is_fast = reg_hit(s_axi_araddr, `PCG_OFF_FAST);
   assign ar_is_periph = reg_hit(s_axi_araddr, `PCG_OFF_PERIPH);
   assign ar_is_unlock = reg_hit(s_axi_araddr, `PCG_OFF_UNLOCK);

   // ************************************************************
   // write channel: address and data taken in either order
   // ************************************************************
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 12'h000;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PCG_RESP_OKAY;
      end
      else
      begin
         // ready is offered one cycle ahead so each channel is taken once
         s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         // both halves held: commit, answer, and keep both channels shut until bready
         if (do_write)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            // an unmapped place is answered with an error and changes nothing
            if (aw_mapped)
               s_axi_bresp <= `PCG_RESP_OKAY;
            else
               s_axi_bresp <= `PCG_RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // ************************************************************
   // clock enable registers and unlock sequencer
   // ************************************************************
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         fast_bus_clock_gate <= `PCG_FAST_RESET;
         peripheral_bus_clock_gate <= `PCG_PERIPH_RESET;
         key_stage <= KEY_IDLE;
         unlocked <= 1'b0;
      end
      else if (do_write)
      begin
         // each register takes the write only when its own word is addressed
         if (aw_is_fast)
            fast_bus_clock_gate <= next_fast;
         if (aw_is_periph)
            peripheral_bus_clock_gate <= next_periph;
         // any break in the key sequence restarts it; a full key opens, any other first byte locks
         // key bytes ride on lane 0 only, a write without that lane leaves the sequencer alone
         if (aw_is_unlock && w_strb[0])
         begin
            case (key_stage)
               KEY_IDLE:
               begin
                  key_stage <= (w_data[7:0] == `PCG_KEY0) ? KEY_GOT1 : KEY_IDLE;
                  if (w_data[7:0] != `PCG_KEY0)
                     unlocked <= 1'b0;
               end
               KEY_GOT1:
                  key_stage <= (w_data[7:0] == `PCG_KEY1) ? KEY_GOT2 : KEY_IDLE;
               KEY_GOT2:
               begin
                  key_stage <= KEY_IDLE;
                  if (w_data[7:0] == `PCG_KEY2)
                     unlocked <= 1'b1;
               end
               default:
                  key_stage <= KEY_IDLE;
            endcase
         end
      end
   end

   // ************************************************************
   // read channel: one read at a time, answered a cycle after address
   // ************************************************************
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `PCG_RESP_OKAY;
      end
      else
      begin
         // ready is offered on alternate idle cycles, mirroring the write side
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `PCG_RESP_OKAY;
            // the reply is a snapshot taken at the address edge and stands until rready
            if (ar_is_fast)
               s_axi_rdata <= fast_bus_clock_gate & `PCG_FAST_MASK;
            else if (ar_is_periph)
               s_axi_rdata <= peripheral_bus_clock_gate & `PCG_PERIPH_MASK;
            else if (ar_is_unlock)
               s_axi_rdata <= {31'h00000000, unlocked};
            else
            begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `PCG_RESP_SLVERR;
            end
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // ************************************************************
   // clock gates
   // ************************************************************
   // enable bits in output order, flash gate first
   wire [`PCG_NUM_CLK-1:0] gate_en;
   wire [`PCG_NUM_CLK-1:0] gate_out;
   assign gate_en = {fast_bus_clock_gate[`PCG_BIT_FLASH],
      peripheral_bus_clock_gate[`PCG_BIT_ADC],
      peripheral_bus_clock_gate[`PCG_BIT_CAN],
      peripheral_bus_clock_gate[`PCG_BIT_SER2],
      peripheral_bus_clock_gate[`PCG_BIT_SER1],
      peripheral_bus_clock_gate[`PCG_BIT_SER0],
      peripheral_bus_clock_gate[`PCG_BIT_SPI],
      peripheral_bus_clock_gate[`PCG_BIT_I2C1],
      peripheral_bus_clock_gate[`PCG_BIT_I2C0],
      peripheral_bus_clock_gate[`PCG_BIT_FDIV],
      peripheral_bus_clock_gate[`PCG_BIT_TMR3],
      peripheral_bus_clock_gate[`PCG_BIT_TMR2],
      peripheral_bus_clock_gate[`PCG_BIT_TMR1],
      peripheral_bus_clock_gate[`PCG_BIT_TMR0],
      peripheral_bus_clock_gate[`PCG_BIT_WDOG]};

   // enables change only after a rising edge, so falling-edge gating never chops a pulse
   genvar gi;
   generate
      for (gi = 0; gi < `PCG_NUM_CLK; gi = gi + 1)
      begin : g_gate
         pcg_gate u_gate
         (
            .clk_in(clock),
            .enable(gate_en[gi]),
            .clk_out(gate_out[gi])
         );
      end
   endgenerate

   // one gate per peripheral; the order here matches gate_en above
   assign {flash_prog_clk, adc_clk, can_ctrl_clk, serial_port2_clk, serial_port1_clk, serial_port0_clk,
      spi_ctrl_clk, i2c_ctrl1_clk, i2c_ctrl0_clk, freq_divider_clk, timer3_clk, timer2_clk, timer1_clk,
      timer0_clk, watchdog_clk} = gate_out;
endmodule
`default_nettype wire

// File: inc/pcg_consts.vh
// constants for the peripheral clock gating block
`ifndef PCG_CONSTS_VH
`define PCG_CONSTS_VH
`define PCG_ADDR_W 12
`define PCG_OFF_FAST 12'h004
`define PCG_OFF_PERIPH 12'h008
`define PCG_OFF_UNLOCK 12'h100
`define PCG_FAST_RESET 32'h00000005
`define PCG_FAST_MASK 32'h00000004
`define PCG_PERIPH_RESET 32'h00000000
`define PCG_PERIPH_MASK 32'h1107137D
`define PCG_BIT_FLASH 2
`define PCG_BIT_ADC 28
`define PCG_BIT_CAN 24
`define PCG_BIT_SER2 18
`define PCG_BIT_SER1 17
`define PCG_BIT_SER0 16
`define PCG_BIT_SPI 12
`define PCG_BIT_I2C1 9
`define PCG_BIT_I2C0 8
`define PCG_BIT_FDIV 6
`define PCG_BIT_TMR3 5
`define PCG_BIT_TMR2 4
`define PCG_BIT_TMR1 3
`define PCG_BIT_TMR0 2
`define PCG_BIT_WDOG 0
`define PCG_KEY0 8'h59
`define PCG_KEY1 8'h16
`define PCG_KEY2 8'h88
`define PCG_RESP_OKAY 2'h0
`define PCG_RESP_SLVERR 2'h2
`define PCG_NUM_CLK 15
`endif
